// File: bench/testbench.sv
/*
  Self-checking bench for stimulus_drive_control. It drives the Avalon-MM
  register bus and the compliance comparator inputs, then checks the
  registers and the drive outputs.
  Assumes the stim_pkg package and a 100 MHz system clock.
*/
`timescale 1ns/1ps
module testbench;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        clk_sys_in;
  logic        rstn_in;
  logic [9:0]  avs_address_in;
  logic        avs_read_in;
  logic        avs_write_in;
  logic [31:0] avs_writedata_in;
  logic [3:0]  avs_byteenable_in;
  logic [31:0] avs_readdata_out;
  logic [1:0]  avs_response_out;
  logic        avs_waitrequest_out;
  logic        swing_low_in;
  logic        swing_high_in;
  logic        irq_out;
  logic        synth_en_out;
  logic        idac_en_out;
  logic        return_clamp_out;
  logic        amp_lowpower_out;
  logic        hbridge_en_out;
  logic        follower_en_out;
  logic        vdrv_to_first_out;
  logic [3:0]  range_res_sel_out;
  logic        ext_res_sel_out;
  logic [1:0]  amp_range_out;
  logic [1:0]  amp_bandwidth_out;
  logic [3:0]  current_step_out;
  logic [6:0]  drv;
  int          failures;
  int          n_tests;

  // Per mode: synth, idac, clamp, lowpower, hbridge, follower, vdrv
  localparam logic [6:0]  MODE_EXP [4]  = '{7'h60, 7'h63, 7'h04, 7'h58};
  localparam logic [6:0]  MODE_MASK [4] = '{7'h7F, 7'h7F, 7'h7E, 7'h5F};
  localparam logic [31:0] CF_FREQ [5]   = '{32'h4000, 32'h3FFF, 32'h1FFF, 32'h7FF, 32'h1FF};
  localparam logic [31:0] CF_EXP [5]    = '{32'h3C, 32'h2C, 32'h1C, 32'h0C, 32'h38};

  assign drv = {synth_en_out, idac_en_out, return_clamp_out, amp_lowpower_out,
                hbridge_en_out, follower_en_out, vdrv_to_first_out};

  stimulus_drive_control stimulus_drive_control_inst (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_response_out(avs_response_out), .avs_waitrequest_out(avs_waitrequest_out),
    .swing_low_in(swing_low_in), .swing_high_in(swing_high_in), .irq_out(irq_out),
    .synth_en_out(synth_en_out), .idac_en_out(idac_en_out), .return_clamp_out(return_clamp_out),
    .amp_lowpower_out(amp_lowpower_out), .hbridge_en_out(hbridge_en_out),
    .follower_en_out(follower_en_out), .vdrv_to_first_out(vdrv_to_first_out),
    .range_res_sel_out(range_res_sel_out), .ext_res_sel_out(ext_res_sel_out),
    .amp_range_out(amp_range_out), .amp_bandwidth_out(amp_bandwidth_out),
    .current_step_out(current_step_out));

  always #5 clk_sys_in = ~clk_sys_in;

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One bus access; request held until waitrequest is seen low at an edge
  task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    avs_address_in   <= a;
    avs_writedata_in <= d;
    avs_write_in     <= wr;
    avs_read_in      <= ~wr;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 100);
    rd = avs_readdata_out;
    rs = avs_response_out;
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
    if (n >= 100) chk(32'h0, 32'h1, "bus timeout");
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic [1:0]  rs;
    xfer(1'b1, a, d, rd, rs);
  endtask

  task automatic rdchk(input logic [9:0] a, input logic [31:0] exp, input logic [1:0] rexp, input string what);
    logic [31:0] rd;
    logic [1:0]  rs;
    xfer(1'b0, a, 32'h0, rd, rs);
    chk({30'h0, rs}, {30'h0, rexp}, what);
    chk(rd, exp, what);
  endtask

  task automatic settle();
    repeat (4) @(posedge clk_sys_in);
  endtask

  // ------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    failures++;
    complete_run();
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0; rstn_in = 1'b0; avs_address_in = 10'h0; avs_read_in = 1'b0;
    avs_write_in = 1'b0; avs_writedata_in = 32'h0; avs_byteenable_in = 4'hF;
    swing_low_in = 1'b0; swing_high_in = 1'b0; failures = 0; n_tests = 0;
    repeat (20) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    rdchk(stim_pkg::ADDR_DRIVE_CFG, 32'h03, 2'h0, "reset cfg");
    rdchk(stim_pkg::ADDR_AMP_CFG, 32'h0, 2'h0, "reset amp");
    chk({25'h0, drv & MODE_MASK[3]}, {25'h0, MODE_EXP[3] & MODE_MASK[3]}, "reset standby");
    $display("test reset done");
    wr(stim_pkg::ADDR_FREQ, 32'h4E20);
    for (int m = 0; m < 4; m++) begin
      wr(stim_pkg::ADDR_DRIVE_CFG, {30'h9, m[1:0]});
      settle();
      chk({25'h0, drv & MODE_MASK[m]}, {25'h0, MODE_EXP[m] & MODE_MASK[m]}, "mode outputs");
      if (m == 2) chk({28'h0, range_res_sel_out}, 32'h0, "hbridge switches open");
    end
    $display("test modes done");
    for (int i = 0; i < 16; i++) begin
      wr(stim_pkg::ADDR_DRIVE_CFG, {26'h0, i[1:0], i[3:2], 2'h0});
      settle();
      chk({28'h0, current_step_out}, i, "current step");
      chk({28'h0, range_res_sel_out}, {28'h0, 4'h1 << i[3:2]}, "range resistor");
      chk({31'h0, ext_res_sel_out}, 32'h0, "internal resistor");
    end
    wr(stim_pkg::ADDR_DRIVE_CFG, 32'h84);
    settle();
    chk({27'h0, ext_res_sel_out, range_res_sel_out}, 32'h10, "external resistor");
    wr(stim_pkg::ADDR_AMP_CFG, 32'hE);
    settle();
    chk({28'h0, amp_range_out, amp_bandwidth_out}, 32'hE, "amp fields");
    rdchk(stim_pkg::ADDR_AMP_CFG, 32'hE, 2'h0, "amp readback");
    $display("test decode done");
    wr(stim_pkg::ADDR_IRQ_CLR, 32'h3);
    for (int k = 0; k < 5; k++) begin
      wr(stim_pkg::ADDR_FREQ, 32'h4E20);
      wr(stim_pkg::ADDR_DRIVE_CFG, 32'h3C);
      wr(stim_pkg::ADDR_FREQ, CF_FREQ[k]);
      settle();
      rdchk(stim_pkg::ADDR_DRIVE_CFG, CF_EXP[k], 2'h0, "clamp on freq write");
      chk({28'h0, current_step_out}, {28'h0, CF_EXP[k][3:2], CF_EXP[k][5:4]}, "clamped step");
    end
    wr(stim_pkg::ADDR_FREQ, 32'h258);
    wr(stim_pkg::ADDR_DRIVE_CFG, 32'h3C);
    settle();
    rdchk(stim_pkg::ADDR_DRIVE_CFG, 32'h0C, 2'h0, "clamp on cfg write");
    rdchk(stim_pkg::ADDR_IRQ_STAT, 32'h2, 2'h0, "clamp status");
    wr(stim_pkg::ADDR_IRQ_EN, 32'h2);
    settle();
    chk({31'h0, irq_out}, 32'h1, "clamp irq");
    wr(stim_pkg::ADDR_IRQ_CLR, 32'h2);
    settle();
    chk({31'h0, irq_out}, 32'h0, "clamp irq cleared");
    $display("test clamp done");
    wr(stim_pkg::ADDR_IRQ_EN, 32'h1);
    swing_high_in <= 1'b1;
    settle();
    settle();
    rdchk(stim_pkg::ADDR_IRQ_STAT, 32'h0, 2'h0, "monitor off");
    wr(stim_pkg::ADDR_CTRL, 32'h1);
    settle();
    rdchk(stim_pkg::ADDR_IRQ_STAT, 32'h1, 2'h0, "high swing flag");
    chk({31'h0, irq_out}, 32'h1, "compliance irq");
    swing_high_in <= 1'b0;
    settle();
    wr(stim_pkg::ADDR_IRQ_CLR, 32'h1);
    settle();
    rdchk(stim_pkg::ADDR_IRQ_STAT, 32'h0, 2'h0, "flag cleared");
    wr(stim_pkg::ADDR_IRQ_EN, 32'h0);
    swing_low_in <= 1'b1;
    settle();
    settle();
    rdchk(stim_pkg::ADDR_IRQ_STAT, 32'h1, 2'h0, "low swing flag");
    chk({31'h0, irq_out}, 32'h0, "masked irq");
    swing_low_in <= 1'b0;
    $display("test compliance done");
    rdchk(10'h3FC, 32'h0, 2'h2, "unmapped read");
    wr(stim_pkg::ADDR_IRQ_STAT, 32'h0);
    rdchk(stim_pkg::ADDR_IRQ_CLR, 32'h0, 2'h0, "clear reads zero");
    $display("test refusals done");
    complete_run();
  end
endmodule // testbench

// File: verilog/stim_pkg.sv
/*
  Constants for the stimulus drive control block: register map, field
  positions, reset values, mode codes and frequency thresholds.
  Assumes a 32-bit Avalon-MM register bus with word addressing by byte.
*/
package stim_pkg;
  // ------------------------------------------------------------
  // Register byte addresses (index times four)
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_DRIVE_CFG  = 8'h22;
  localparam logic [7:0] IDX_AMP_CFG    = 8'h25;
  localparam logic [9:0] ADDR_DRIVE_CFG = 10'h088;
  localparam logic [9:0] ADDR_AMP_CFG   = 10'h094;
  localparam logic [9:0] ADDR_FREQ      = 10'h100;
  localparam logic [9:0] ADDR_CTRL      = 10'h104;
  localparam logic [9:0] ADDR_IRQ_STAT  = 10'h108;
  localparam logic [9:0] ADDR_IRQ_EN    = 10'h10C;
  localparam logic [9:0] ADDR_IRQ_CLR   = 10'h110;
  localparam logic [9:0] ADDR_DRV_STAT  = 10'h114;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int MODE_LSB   = 0;
  localparam int RANGE_LSB  = 2;
  localparam int MAG_LSB    = 4;
  localparam int EXTRES_BIT = 7;
  localparam int BW_LSB     = 0;
  localparam int AMPRG_LSB  = 2;
  localparam int CMON_BIT   = 0;
  localparam int IRQ_OOR    = 0;
  localparam int IRQ_CLAMP  = 1;
  localparam int IRQ_W      = 2;

  // ------------------------------------------------------------
  // Reset values and codes
  // ------------------------------------------------------------
  localparam logic [7:0]  DRIVE_CFG_RST = 8'h03;
  localparam logic [3:0]  AMP_CFG_RST   = 4'h0;
  localparam logic [31:0] FREQ_RST      = 32'h0000_0000;
  localparam logic [1:0]  MODE_CURRENT  = 2'h0;
  localparam logic [1:0]  MODE_VOLTAGE  = 2'h1;
  localparam logic [1:0]  MODE_HBRIDGE  = 2'h2;
  localparam logic [1:0]  MODE_STANDBY  = 2'h3;
  localparam logic [1:0]  RANGE_TOP     = 2'h3;

  // Least frequency (Hz) per magnitude on the top range
  localparam logic [31:0] FREQ_MIN_MAG0 = 32'd512;
  localparam logic [31:0] FREQ_MIN_MAG1 = 32'd2048;
  localparam logic [31:0] FREQ_MIN_MAG2 = 32'd8192;
  localparam logic [31:0] FREQ_MIN_MAG3 = 32'd16384;

  localparam logic [31:0] SLV_ERR_DATA  = 32'h0000_0000;
endpackage

// File: verilog/stim_safety_clamp.sv
/*
  Safety clamp: maps a requested range and magnitude at a given stimulus
  frequency to the highest allowed pair. Purely combinational.
  Assumes the frequency word is the stimulus frequency in Hz.
*/
`timescale 1ns/1ps
module stim_safety_clamp (
  input  wire logic [1:0]  range_in,
  input  wire logic [1:0]  mag_in,
  input  wire logic [31:0] freq_in,
  output logic      [1:0]  range_out,
  output logic      [1:0]  mag_out,
  output logic             clamped_out
);
  logic [3:0] allowed;

  // ------------------------------------------------------------
  // Allowed magnitudes on the top range
  // ------------------------------------------------------------
  assign allowed[0] = freq_in >= stim_pkg::FREQ_MIN_MAG0;
  assign allowed[1] = freq_in >= stim_pkg::FREQ_MIN_MAG1;
  assign allowed[2] = freq_in >= stim_pkg::FREQ_MIN_MAG2;
  assign allowed[3] = freq_in >= stim_pkg::FREQ_MIN_MAG3;

  always_comb begin
    range_out   = range_in;
    mag_out     = mag_in;
    clamped_out = 1'b0;
    if (range_in == stim_pkg::RANGE_TOP && !allowed[mag_in]) begin
      clamped_out = 1'b1;
      if (allowed[2]) begin
        mag_out = 2'h2;
      end else if (allowed[1]) begin
        mag_out = 2'h1;
      end else if (allowed[0]) begin
        mag_out = 2'h0;
      end else begin
        range_out = 2'h2;
        mag_out   = 2'h3;
      end
    end
  end
endmodule // stim_safety_clamp

// File: verilog/stimulus_drive_control.sv
/*
  Stimulus drive control for the bioimpedance transmit channel: mode
  decode, range and magnitude decode with safety clamp, compliance monitor
  status and interrupt, registers over Avalon-MM with waitrequest.
  Assumes one 100 MHz clock, synchronous active-low reset, and compliance
  comparator outputs arriving asynchronously from the analog side.
*/
// Operation
// - mode code 3 selects low-power standby
// - standby keeps synthesizer on, closes return clamp
// - standby idles amplifiers and disables H-bridge
// - mode 0 runs sine current stimulus
// - current mode drives synthesizer into current DAC
// - range field selects one of four resistors, none in H-bridge mode
// - external resistor bit replaces internal resistor
// - amplifier range and bandwidth from register fields
// - range and magnitude give sixteen current steps
// - disallowed setting rewritten to highest allowed
// - top range magnitudes need minimum frequencies
// - monitor enabled and swing exceeded sets flag
// - mode 1 runs voltage stimulus with follower
// - mode 2 runs H-bridge, synthesizer off
`timescale 1ns/1ps
module stimulus_drive_control (
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  input  wire logic [9:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic      [1:0]  avs_response_out,
  output logic             avs_waitrequest_out,
  input  wire logic        swing_low_in,
  input  wire logic        swing_high_in,
  output logic             irq_out,
  output logic             synth_en_out,
  output logic             idac_en_out,
  output logic             return_clamp_out,
  output logic             amp_lowpower_out,
  output logic             hbridge_en_out,
  output logic             follower_en_out,
  output logic             vdrv_to_first_out,
  output logic      [3:0]  range_res_sel_out,
  output logic             ext_res_sel_out,
  output logic      [1:0]  amp_range_out,
  output logic      [1:0]  amp_bandwidth_out,
  output logic      [3:0]  current_step_out
);
  typedef struct packed {
    logic [7:0]  drive_cfg;
    logic [3:0]  amp_cfg;
    logic [31:0] freq;
    logic        cmon_en;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_en;
    logic [1:0]  lo_sync;
    logic [1:0]  hi_sync;
    logic        ack;
    logic [31:0] rdata;
    logic [1:0]  resp;
    logic [9:0]  outs;
    logic [3:0]  range_res;
    logic [3:0]  step;
  } state_t;

  state_t st;
  state_t next_st;

  logic [1:0]  clamp_range;
  logic [1:0]  clamp_mag;
  logic        clamp_hit;
  logic [31:0] wmask;
  logic        req;
  logic        wr_go;
  logic        mapped;
  logic        oor;
  logic [1:0]  mode;

  // ------------------------------------------------------------
  // Safety clamp on the stored setting
  // ------------------------------------------------------------
  stim_safety_clamp u_clamp (
    .range_in    (st.drive_cfg[stim_pkg::RANGE_LSB +: 2]),
    .mag_in      (st.drive_cfg[stim_pkg::MAG_LSB +: 2]),
    .freq_in     (st.freq),
    .range_out   (clamp_range),
    .mag_out     (clamp_mag),
    .clamped_out (clamp_hit)
  );

  generate
    for (genvar b = 0; b < 4; b++) begin : g_mask
      assign wmask[8*b +: 8] = {8{avs_byteenable_in[b]}};
    end
  endgenerate

  assign req   = (avs_read_in || avs_write_in) && !st.ack;
  // Write lands at the edge where waitrequest is seen low
  assign wr_go = avs_write_in && st.ack;
  assign mapped = avs_address_in inside {stim_pkg::ADDR_DRIVE_CFG, stim_pkg::ADDR_AMP_CFG, stim_pkg::ADDR_FREQ,
                                         stim_pkg::ADDR_CTRL, stim_pkg::ADDR_IRQ_STAT, stim_pkg::ADDR_IRQ_EN,
                                         stim_pkg::ADDR_IRQ_CLR, stim_pkg::ADDR_DRV_STAT};
  assign mode  = st.drive_cfg[stim_pkg::MODE_LSB +: 2];
  // Second sync stage only
  assign oor   = st.cmon_en && (st.lo_sync[1] || st.hi_sync[1]);

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.lo_sync = {st.lo_sync[0], swing_low_in};
    next_st.hi_sync = {st.hi_sync[0], swing_high_in};
    next_st.ack  = req;
    next_st.resp = 2'h0;
    // Response stands with the answer, for reads and writes alike
    if (req && !mapped) begin
      next_st.resp = 2'h2;
    end

    // Bus writes
    if (wr_go) begin
      unique case (avs_address_in)
        stim_pkg::ADDR_DRIVE_CFG: next_st.drive_cfg = (st.drive_cfg & ~wmask[7:0]) | (avs_writedata_in[7:0] & wmask[7:0]);
        stim_pkg::ADDR_AMP_CFG:   next_st.amp_cfg = (st.amp_cfg & ~wmask[3:0]) | (avs_writedata_in[3:0] & wmask[3:0]);
        stim_pkg::ADDR_FREQ:      next_st.freq = (st.freq & ~wmask) | (avs_writedata_in & wmask);
        stim_pkg::ADDR_CTRL:      next_st.cmon_en = wmask[0] ? avs_writedata_in[stim_pkg::CMON_BIT] : st.cmon_en;
        stim_pkg::ADDR_IRQ_EN:    next_st.irq_en = (st.irq_en & ~wmask[1:0]) | (avs_writedata_in[1:0] & wmask[1:0]);
        stim_pkg::ADDR_IRQ_CLR:   next_st.irq_stat = st.irq_stat & ~(avs_writedata_in[1:0] & wmask[1:0]);
        stim_pkg::ADDR_IRQ_STAT, stim_pkg::ADDR_DRV_STAT: ;
        default:                  ;
      endcase
    end

    // Clamp rewrite one cycle after any offending setting
    if (clamp_hit && !(wr_go && (avs_address_in == stim_pkg::ADDR_DRIVE_CFG || avs_address_in == stim_pkg::ADDR_FREQ))) begin
      next_st.drive_cfg[stim_pkg::RANGE_LSB +: 2] = clamp_range;
      next_st.drive_cfg[stim_pkg::MAG_LSB +: 2]   = clamp_mag;
    end

    // Events win over clear
    if (oor) begin
      next_st.irq_stat[stim_pkg::IRQ_OOR] = 1'b1;
    end
    if (clamp_hit) begin
      next_st.irq_stat[stim_pkg::IRQ_CLAMP] = 1'b1;
    end

    // Bus reads
    next_st.rdata = 32'h0000_0000;
    if (avs_read_in && !st.ack) begin
      unique case (avs_address_in)
        stim_pkg::ADDR_DRIVE_CFG: next_st.rdata = {24'h000000, st.drive_cfg};
        stim_pkg::ADDR_AMP_CFG:   next_st.rdata = {28'h0000000, st.amp_cfg};
        stim_pkg::ADDR_FREQ:      next_st.rdata = st.freq;
        stim_pkg::ADDR_CTRL:      next_st.rdata = {31'h00000000, st.cmon_en};
        stim_pkg::ADDR_IRQ_STAT:  next_st.rdata = {30'h00000000, st.irq_stat};
        stim_pkg::ADDR_IRQ_EN:    next_st.rdata = {30'h00000000, st.irq_en};
        stim_pkg::ADDR_IRQ_CLR:   next_st.rdata = 32'h0000_0000;
        stim_pkg::ADDR_DRV_STAT:  next_st.rdata = {27'h0000000, st.step, oor};
        default: begin
          next_st.rdata = stim_pkg::SLV_ERR_DATA;
        end
      endcase
    end

    // Analog control decode, registered
    // outs: synth, idac, clamp, lowpwr, hbridge, follower, vdrv_first, ext, spare
    next_st.outs      = 10'h000;
    next_st.range_res = 4'h0;
    unique case (mode)
      stim_pkg::MODE_CURRENT: begin
        next_st.outs[0] = 1'b1;
        next_st.outs[1] = 1'b1;
      end
      stim_pkg::MODE_VOLTAGE: begin
        next_st.outs[0] = 1'b1;
        next_st.outs[1] = 1'b1;
        next_st.outs[5] = 1'b1;
        next_st.outs[6] = 1'b1;
      end
      stim_pkg::MODE_HBRIDGE: begin
        next_st.outs[4] = 1'b1;
      end
      stim_pkg::MODE_STANDBY: begin
        next_st.outs[0] = 1'b1;
        next_st.outs[2] = 1'b1;
        next_st.outs[3] = 1'b1;
      end
    endcase
    if (mode != stim_pkg::MODE_HBRIDGE) begin
      if (st.drive_cfg[stim_pkg::EXTRES_BIT]) begin
        next_st.outs[7] = 1'b1;
      end else begin
        next_st.range_res[st.drive_cfg[stim_pkg::RANGE_LSB +: 2]] = 1'b1;
      end
    end
    // Step index: range major, magnitude minor
    next_st.step = {st.drive_cfg[stim_pkg::RANGE_LSB +: 2], st.drive_cfg[stim_pkg::MAG_LSB +: 2]};
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      st           <= '0;
      st.drive_cfg <= stim_pkg::DRIVE_CFG_RST;
      st.amp_cfg   <= stim_pkg::AMP_CFG_RST;
      st.freq      <= stim_pkg::FREQ_RST;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign avs_waitrequest_out = !st.ack;
  assign avs_readdata_out    = st.rdata;
  assign avs_response_out    = st.resp;
  assign irq_out             = |(st.irq_stat & st.irq_en);
  assign synth_en_out        = st.outs[0];
  assign idac_en_out         = st.outs[1];
  assign return_clamp_out    = st.outs[2];
  assign amp_lowpower_out    = st.outs[3];
  assign hbridge_en_out      = st.outs[4];
  assign follower_en_out     = st.outs[5];
  assign vdrv_to_first_out   = st.outs[6];
  assign ext_res_sel_out     = st.outs[7];
  assign range_res_sel_out   = st.range_res;
  assign amp_range_out       = st.amp_cfg[stim_pkg::AMPRG_LSB +: 2];
  assign amp_bandwidth_out   = st.amp_cfg[stim_pkg::BW_LSB +: 2];
  assign current_step_out    = st.step;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  AST_STANDBY: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    mode == stim_pkg::MODE_STANDBY |=> synth_en_out && return_clamp_out && !hbridge_en_out)
    else $error("standby outputs wrong");
  AST_STANDBY_LP: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    mode == stim_pkg::MODE_STANDBY |=> amp_lowpower_out)
    else $error("standby not low power");
  AST_MODE_DECODE: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    mode == 2'h3 |=> !idac_en_out)
    else $error("standby decode wrong");
  AST_CURRENT: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    mode == stim_pkg::MODE_CURRENT |=> synth_en_out && idac_en_out && !return_clamp_out)
    else $error("current mode outputs wrong");
  AST_IDAC: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    idac_en_out |-> synth_en_out)
    else $error("dac without synthesizer");
  AST_VOLTAGE: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    mode == stim_pkg::MODE_VOLTAGE |=> follower_en_out && vdrv_to_first_out)
    else $error("voltage mode outputs wrong");
  AST_HBRIDGE: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    mode == stim_pkg::MODE_HBRIDGE |=> hbridge_en_out && !synth_en_out && range_res_sel_out == 4'h0)
    else $error("hbridge outputs wrong");
  AST_ONE_RES: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    $countones(range_res_sel_out) <= 1)
    else $error("more than one range resistor");
  AST_EXT_RES: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    ext_res_sel_out |-> range_res_sel_out == 4'h0)
    else $error("external and internal resistor together");
  AST_AMP: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    amp_range_out == st.amp_cfg[3:2] && amp_bandwidth_out == st.amp_cfg[1:0])
    else $error("amplifier fields wrong");
  AST_STEP: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    1'b1 |=> current_step_out == {$past(st.drive_cfg[3:2]), $past(st.drive_cfg[5:4])})
    else $error("current step wrong");
  AST_CLAMP: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    clamp_hit |-> ##[1:2] !clamp_hit || $changed(st.freq))
    else $error("disallowed setting persisted");
  AST_TOP_LIMIT: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    clamp_hit && !wr_go |=> st.drive_cfg[5:4] == $past(clamp_mag))
    else $error("clamp did not rewrite magnitude");
  AST_FREQ_RULE: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    st.drive_cfg[3:2] == 2'h3 && st.drive_cfg[5:4] == 2'h3 && st.freq < 32'd16384 |-> clamp_hit)
    else $error("top step allowed below limit");
  AST_OOR: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    oor |=> st.irq_stat[stim_pkg::IRQ_OOR])
    else $error("compliance flag not set");
endmodule // stimulus_drive_control
